// ===== include/nwc_pkg.sv
`default_nettype none
package nwc_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SCREEN = 8'h04;
	localparam logic [7:0] OFS_SEL = 8'h08;
	localparam logic [7:0] OFS_CFG = 8'h0c;
	localparam logic [7:0] OFS_VALUE = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_HOSTCMD = 8'h18;

	// field positions
	localparam int CTRL_START = 0;
	localparam int CFG_MAPPED = 0;
	localparam int CFG_TWO = 1;
	localparam int CFG_BCD = 2;
	localparam int CFG_INIT = 3;
	localparam int CFG_TC_AREA = 4;
	localparam int CFG_ADDR_LSB = 16;
	localparam int STAT_BUSY = 0;
	localparam int STAT_CFG_REJ = 1;
	localparam int STAT_BCD_BAD = 2;
	localparam int CMD_WRITE = 8;

	// number formats
	localparam int DIGITS_ONE = 4;
	localparam int DIGITS_TWO = 8;
	localparam logic [3:0] BCD_NEG = 4'hf;
	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
	localparam logic [31:0] RESET_SCREEN = 32'h0000_0000;

	// per-entry host mapping
	typedef struct packed {
		logic [15:0] addr;
		logic tc_area;
		logic init;
		logic bcd;
		logic two;
		logic mapped;
	} nwc_cfg_t;

	localparam nwc_cfg_t RESET_CFG = '0;

	// request towards the host word memory
	typedef struct packed {
		logic valid;
		logic write;
		logic two;
		logic [15:0] addr;
		logic [31:0] wdata;
	} nwc_host_req_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SWEEP = 2'b01,
		ST_WAIT = 2'b11
	} nwc_state_t;

endpackage : nwc_pkg
`default_nettype wire

// ===== src/nwc_codec.sv
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module nwc_codec #(
	parameter int N = 16
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// host word link
	output nwc_pkg::nwc_host_req_t host_req,
	input wire logic host_rd_valid,
	input wire logic [31:0] host_rd_data
);

	localparam int IW = (N > 1) ? $clog2(N) : 1;
	localparam logic [IW-1:0] LAST_IDX = IW'(N - 1);

	typedef struct packed {
		logic [N-1:0][31:0] val;
		nwc_pkg::nwc_cfg_t [N-1:0] cfg;
		logic [N-1:0] screen;
		logic [IW-1:0] sel;
		logic [IW-1:0] idx;
		nwc_pkg::nwc_state_t st;
		logic single;
		logic cfg_rej;
		logic bcd_bad;
		logic a_wr;
		logic a_rd;
		logic [7:0] a_addr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
		nwc_pkg::nwc_host_req_t req;
	} nwc_core_t;

	nwc_core_t s_reg;
	nwc_core_t s_next;

	// packed bcd to signed binary; bit 32 flags illegal data
	function automatic logic [32:0] bcd_decode(input logic [31:0] d, input logic two);
		logic [31:0] mag;
		logic bad;
		logic neg;
		logic [3:0] top;
		logic [3:0] nib;
		int nd;
		nd = two ? nwc_pkg::DIGITS_TWO : nwc_pkg::DIGITS_ONE;
		top = two ? d[31:28] : d[15:12];
		neg = (top == nwc_pkg::BCD_NEG);
		bad = (top > nwc_pkg::BCD_MAX) && !neg;
		mag = 32'h0000_0000;
		for (int i = nwc_pkg::DIGITS_TWO - 1; i >= 0; i--) begin
			if (i < nd) begin
				nib = d[i*4 +: 4];
				if (i == nd - 1) begin
					if (neg) begin
						nib = 4'h0;
					end
				end else if (nib > nwc_pkg::BCD_MAX) begin
					bad = 1'b1;
				end
				mag = 32'(mag * 32'd10) + {28'h0, nib};
			end
		end
		if (neg) begin
			mag = ~mag + 32'h0000_0001;
		end
		return {bad, mag};
	endfunction : bcd_decode

	// signed binary to packed bcd, low digits only
	function automatic logic [31:0] bcd_encode(input logic [31:0] v, input logic two);
		logic [31:0] mag;
		logic [31:0] out;
		logic neg;
		int nd;
		nd = two ? nwc_pkg::DIGITS_TWO : nwc_pkg::DIGITS_ONE;
		neg = v[31];
		mag = neg ? (~v + 32'h0000_0001) : v;
		out = 32'h0000_0000;
		for (int i = 0; i < nwc_pkg::DIGITS_TWO; i++) begin
			if (i < nd) begin
				out[i*4 +: 4] = 4'(mag % 32'd10);
				mag = mag / 32'd10;
			end
		end
		if (neg) begin
			out[(nd-1)*4 +: 4] = nwc_pkg::BCD_NEG;
		end
		return out;
	endfunction : bcd_encode

	// entry value to host words
	function automatic logic [31:0] to_host(input logic [31:0] v, input nwc_pkg::nwc_cfg_t c);
		logic [31:0] w;
		if (c.mapped && c.bcd) begin
			w = bcd_encode(v, c.two);
		end else begin
			w = c.two ? v : {16'h0000, v[15:0]};
		end
		return w;
	endfunction : to_host

	// host words to entry value; bit 32 flags illegal data
	function automatic logic [32:0] from_host(input logic [31:0] d, input nwc_pkg::nwc_cfg_t c);
		logic [31:0] word;
		logic [32:0] res;
		// low half from the lower address
		word = c.two ? d : {16'h0000, d[15:0]};
		if (c.mapped && c.bcd) begin
			res = bcd_decode(word, c.two);
		end else if (c.two) begin
			res = {1'b0, word};
		end else begin
			res = {1'b0, {16{word[15]}}, word[15:0]};
		end
		return res;
	endfunction : from_host

	// entry mapping to its register word
	function automatic logic [31:0] cfg_pack(input nwc_pkg::nwc_cfg_t c);
		logic [31:0] r;
		r = 32'h0000_0000;
		r[nwc_pkg::CFG_MAPPED] = c.mapped;
		r[nwc_pkg::CFG_TWO] = c.two;
		r[nwc_pkg::CFG_BCD] = c.bcd;
		r[nwc_pkg::CFG_INIT] = c.init;
		r[nwc_pkg::CFG_TC_AREA] = c.tc_area;
		r[nwc_pkg::CFG_ADDR_LSB +: 16] = c.addr;
		return r;
	endfunction : cfg_pack

	function automatic nwc_pkg::nwc_cfg_t cfg_unpack(input logic [31:0] d);
		nwc_pkg::nwc_cfg_t c;
		c.mapped = d[nwc_pkg::CFG_MAPPED];
		c.two = d[nwc_pkg::CFG_TWO];
		c.bcd = d[nwc_pkg::CFG_BCD];
		c.init = d[nwc_pkg::CFG_INIT];
		c.tc_area = d[nwc_pkg::CFG_TC_AREA];
		c.addr = d[nwc_pkg::CFG_ADDR_LSB +: 16];
		return c;
	endfunction : cfg_unpack

	// entry index inside the table
	function automatic logic idx_ok(input logic [31:0] d);
		return {24'h0, d[7:0]} < 32'(N);
	endfunction : idx_ok

	// engine idle, shared by start paths and status
	function automatic logic is_idle(input nwc_pkg::nwc_state_t st);
		return st == nwc_pkg::ST_IDLE;
	endfunction : is_idle

	// register read mux
	function automatic logic [31:0] read_reg(input nwc_core_t s, input logic [7:0] a);
		logic [31:0] r;
		nwc_pkg::nwc_cfg_t c;
		c = s.cfg[s.sel];
		r = 32'h0000_0000;
		unique case (a)
			nwc_pkg::OFS_SCREEN: r[N-1:0] = s.screen;
			nwc_pkg::OFS_SEL: r[IW-1:0] = s.sel;
			nwc_pkg::OFS_CFG: r = cfg_pack(c);
			nwc_pkg::OFS_VALUE: r = s.val[s.sel];
			nwc_pkg::OFS_STATUS: begin
				r[nwc_pkg::STAT_BUSY] = !is_idle(s.st);
				r[nwc_pkg::STAT_CFG_REJ] = s.cfg_rej;
				r[nwc_pkg::STAT_BCD_BAD] = s.bcd_bad;
			end
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction : read_reg

	always_comb begin
		logic accept;
		logic step;
		logic [32:0] dec;
		nwc_pkg::nwc_cfg_t c;
		nwc_pkg::nwc_cfg_t wc;
		accept = 1'b0;
		step = 1'b0;
		dec = 33'h0;
		wc = nwc_pkg::RESET_CFG;
		s_next = s_reg;
		c = s_reg.cfg[s_reg.idx];

		// ahb-lite: writes take no wait, reads take one
		accept = hsel && htrans[1] && hready;
		s_next.a_wr = accept && hwrite;
		s_next.a_rd = accept && !hwrite;
		s_next.a_addr = haddr[7:0];
		s_next.hreadyout = !(accept && !hwrite);
		s_next.hresp = 1'b0;
		if (s_reg.a_rd) begin
			s_next.hrdata = read_reg(s_reg, s_reg.a_addr);
		end

		// register writes in the data phase
		if (s_reg.a_wr) begin
			unique case (s_reg.a_addr)
				nwc_pkg::OFS_CTRL: begin
					if (hwdata[nwc_pkg::CTRL_START] && is_idle(s_reg.st)) begin
						s_next.st = nwc_pkg::ST_SWEEP;
						s_next.idx = '0;
						s_next.single = 1'b0;
					end
				end
				nwc_pkg::OFS_SCREEN: s_next.screen = hwdata[N-1:0];
				nwc_pkg::OFS_SEL: begin
					if (idx_ok(hwdata)) begin
						s_next.sel = hwdata[IW-1:0];
					end
				end
				nwc_pkg::OFS_CFG: begin
					wc = cfg_unpack(hwdata);
					if (wc.two && wc.tc_area) begin
						wc.two = 1'b0;
						s_next.cfg_rej = 1'b1;
					end
					s_next.cfg[s_reg.sel] = wc;
				end
				nwc_pkg::OFS_VALUE: s_next.val[s_reg.sel] = hwdata;
				nwc_pkg::OFS_STATUS: begin
					if (hwdata[nwc_pkg::STAT_CFG_REJ]) begin
						s_next.cfg_rej = 1'b0;
					end
					// an engine set further down wins over this clear
					if (hwdata[nwc_pkg::STAT_BCD_BAD]) begin
						s_next.bcd_bad = 1'b0;
					end
				end
				nwc_pkg::OFS_HOSTCMD: begin
					// one entry, direction from its own init flag
					if (idx_ok(hwdata) && is_idle(s_reg.st)) begin
						s_next.st = nwc_pkg::ST_SWEEP;
						s_next.idx = hwdata[IW-1:0];
						s_next.single = 1'b1;
						s_next.cfg[hwdata[IW-1:0]].init = s_reg.cfg[hwdata[IW-1:0]].init;
					end
				end
				default: s_next.hresp = 1'b0;
			endcase
		end

		// host transfer engine
		s_next.req.valid = 1'b0;
		unique case (s_reg.st)
			nwc_pkg::ST_IDLE: step = 1'b0;
			nwc_pkg::ST_SWEEP: begin
				step = 1'b1;
				if (c.mapped) begin
					if (c.init) begin
						s_next.req.valid = 1'b1;
						s_next.req.write = 1'b1;
						s_next.req.two = c.two;
						s_next.req.addr = c.addr;
						s_next.req.wdata = to_host(s_reg.val[s_reg.idx], c);
					end else if (s_reg.screen[s_reg.idx]) begin
						s_next.req.valid = 1'b1;
						s_next.req.write = 1'b0;
						s_next.req.two = c.two;
						s_next.req.addr = c.addr;
						s_next.req.wdata = 32'h0000_0000;
						s_next.st = nwc_pkg::ST_WAIT;
						step = 1'b0;
					end
				end
			end
			nwc_pkg::ST_WAIT: begin
				if (host_rd_valid) begin
					step = 1'b1;
					dec = from_host(host_rd_data, c);
					if (dec[32]) begin
						s_next.bcd_bad = 1'b1;
					end else begin
						s_next.val[s_reg.idx] = dec[31:0];
					end
				end
			end
			default: s_next.st = nwc_pkg::ST_IDLE;
		endcase
		if (step) begin
			if (s_reg.single || s_reg.idx == LAST_IDX) begin
				s_next.st = nwc_pkg::ST_IDLE;
			end else begin
				s_next.st = nwc_pkg::ST_SWEEP;
				s_next.idx = s_reg.idx + 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg <= '0;
			s_reg.hreadyout <= 1'b1;
			s_reg.st <= nwc_pkg::ST_IDLE;
			for (int i = 0; i < N; i++) begin
				s_reg.val[i] <= nwc_pkg::RESET_VALUE;
				s_reg.cfg[i] <= nwc_pkg::RESET_CFG;
			end
			s_reg.screen <= nwc_pkg::RESET_SCREEN[N-1:0];
		end else begin
			s_reg <= s_next;
		end
	end

	assign hrdata = s_reg.hrdata;
	assign hreadyout = s_reg.hreadyout;
	assign hresp = s_reg.hresp;
	assign host_req = s_reg.req;

endmodule : nwc_codec
`default_nettype wire

// ===== test/nwc_codec_checker.sv
`timescale 1ns/1ns
`default_nettype none
module nwc_codec_checker #(
	parameter int N = 16
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// host word link
	input wire nwc_pkg::nwc_host_req_t host_req,
	input wire logic host_rd_valid
);
	logic tk;
	logic rd_tk;
	logic open_reg;
	logic armed_reg;
	assign tk = hsel & htrans[1] & hready;
	assign rd_tk = tk & !hwrite;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			open_reg <= 1'b0;
			armed_reg <= 1'b0;
		end else begin
			if (host_req.valid && !host_req.write) open_reg <= 1'b1;
			else if (host_rd_valid) open_reg <= 1'b0;
			if (tk && hwrite && (haddr[7:0] == nwc_pkg::OFS_CTRL ||
				haddr[7:0] == nwc_pkg::OFS_HOSTCMD)) armed_reg <= 1'b1;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_resp_okay: assert property (hresp == 1'b0) else $error("bad response");
	a_read_wait: assert property (rd_tk |=> !hreadyout ##1 hreadyout) else $error("read wait");
	a_write_nowait: assert property (tk && hwrite |=> hreadyout) else $error("write wait");
	a_req_pulse: assert property (host_req.valid && !host_req.write |=> !host_req.valid)
		else $error("request right after a read request");
	a_one_open: assert property (host_req.valid |-> !open_reg)
		else $error("request while read open");
	a_req_held: assert property (!host_req.valid ##1 !host_req.valid |-> $stable(host_req.addr))
		else $error("idle request moved");
	a_rdata_held: assert property (!$past(rd_tk) && !$past(rd_tk, 2) |-> $stable(hrdata))
		else $error("read data moved");
	a_start_first: assert property (host_req.valid |-> armed_reg)
		else $error("request before start");
endmodule : nwc_codec_checker
bind nwc_codec nwc_codec_checker #(.N(N)) u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .host_req(host_req), .host_rd_valid(host_rd_valid));
`default_nettype wire

// ===== test/nwc_host_mem.sv
`timescale 1ns/1ns
`default_nettype none
module nwc_host_mem (
	// clock
	input wire logic hclk,
	// host word link
	input wire nwc_pkg::nwc_host_req_t host_req,
	output logic host_rd_valid,
	output logic [31:0] host_rd_data
);
	logic [15:0] mem [0:255];
	logic [7:0] ra = '0;
	logic rtwo = 1'b0;
	int delay = 0;
	int cnt = 0;
	logic fire = 1'b0;
	initial host_rd_valid = 1'b0;
	initial host_rd_data = '0;
	always @(posedge hclk) begin
		fire = 1'b0;
		if (host_req.valid && host_req.write) begin
			mem[host_req.addr[7:0]] <= host_req.wdata[15:0];
			if (host_req.two) mem[host_req.addr[7:0] + 8'h1] <= host_req.wdata[31:16];
		end
		if (host_req.valid && !host_req.write) begin
			ra <= host_req.addr[7:0];
			rtwo <= host_req.two;
			cnt = delay + 1;
		end else if (cnt > 0) begin
			cnt = cnt - 1;
			fire = (cnt == 0);
		end
		host_rd_valid <= fire;
		if (fire) begin
			host_rd_data <= {rtwo ? mem[ra + 8'h1] : ~mem[ra], mem[ra]};
		end else begin
			host_rd_data <= ~host_rd_data;
		end
	end
endmodule : nwc_host_mem
`default_nettype wire

// ===== test/test_numeral_table_host_word_codec.sv
`timescale 1ns/1ns
`default_nettype none
module test_numeral_table_host_word_codec;
	// mode is init, bcd, two
	typedef struct packed {
		logic [2:0] mode;
		logic [31:0] host;
		logic [31:0] val;
		logic [31:0] exp;
	} nwc_row_t;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	nwc_pkg::nwc_host_req_t host_req;
	logic host_rd_valid;
	logic [31:0] host_rd_data;
	int failures = 0;
	int checks_done = 0;
	logic [31:0] r;
	logic [15:0] a;
	nwc_row_t rows [16] = '{
		'{3'h2, 32'h1234, 32'h0, 32'h4d2}, '{3'h0, 32'h1234, 32'h0, 32'h1234},
		'{3'h2, 32'hf123, 32'h0, 32'hffffff85}, '{3'h0, 32'hf123, 32'h0, 32'hfffff123},
		'{3'h2, 32'h123b, 32'h55, 32'h55}, '{3'h2, 32'hffff, 32'h55, 32'h55},
		'{3'h2, 32'ha123, 32'h55, 32'h55}, '{3'h3, 32'hf0001234, 32'h0, 32'hfffffb2e},
		'{3'h1, 32'hf0001234, 32'h0, 32'hf0001234}, '{3'h1, 32'hffff, 32'h0, 32'hffff},
		'{3'h3, 32'h12345678, 32'h0, 32'hbc614e}, '{3'h6, 32'h0, 32'h3039, 32'h2345},
		'{3'h6, 32'h0, 32'hfffffb2e, 32'hf234}, '{3'h7, 32'h0, 32'h75bcd15, 32'h23456789},
		'{3'h7, 32'h0, 32'hff439eb2, 32'hf2345678}, '{3'h5, 32'h0, 32'h89abcdef, 32'h89abcdef}};
	always #2 hclk = ~hclk;
	nwc_codec #(.N(16)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .host_req(host_req),
		.host_rd_valid(host_rd_valid), .host_rd_data(host_rd_data));
	nwc_host_mem u_host (.hclk(hclk), .host_req(host_req), .host_rd_valid(host_rd_valid),
		.host_rd_data(host_rd_data));
	task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= {24'h0, ad};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : ahb
	task automatic idle();
		do ahb(1'h0, nwc_pkg::OFS_STATUS, '0); while (r[nwc_pkg::STAT_BUSY] !== 1'b0);
	endtask : idle
	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : check
	task automatic final_report();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'h1, nwc_pkg::OFS_SCREEN, 32'hffff);
		foreach (rows[i]) begin
			a = 16'(2 * i);
			u_host.delay <= i % 3;
			u_host.mem[a] <= rows[i].host[15:0];
			u_host.mem[a + 1] <= rows[i].host[31:16];
			ahb(1'h1, nwc_pkg::OFS_SEL, 32'(i));
			ahb(1'h1, nwc_pkg::OFS_CFG, {a, 12'h0, rows[i].mode, 1'h1});
			ahb(1'h1, nwc_pkg::OFS_VALUE, rows[i].val);
			ahb(1'h1, nwc_pkg::OFS_HOSTCMD, 32'(i));
			idle();
			ahb(1'h0, nwc_pkg::OFS_VALUE, '0);
			if (rows[i].mode[2]) r = {rows[i].mode[0] ? u_host.mem[a + 1] : 16'h0, u_host.mem[a]};
			check("row", rows[i].exp, r);
		end
		ahb(1'h1, nwc_pkg::OFS_SEL, '0);
		ahb(1'h1, nwc_pkg::OFS_CFG, 32'h13);
		ahb(1'h0, nwc_pkg::OFS_CFG, '0);
		check("cfg", 32'h11, r);
		ahb(1'h0, nwc_pkg::OFS_STATUS, '0);
		check("status", 32'h6, r);
		ahb(1'h1, nwc_pkg::OFS_SCREEN, 32'hfffd);
		u_host.mem[2] <= 16'h7777;
		ahb(1'h1, nwc_pkg::OFS_HOSTCMD, 32'h1);
		idle();
		ahb(1'h1, nwc_pkg::OFS_SEL, 32'h1);
		ahb(1'h0, nwc_pkg::OFS_VALUE, '0);
		check("screen", 32'h1234, r);
		u_host.mem[4] <= 16'h0042;
		u_host.mem[30] <= '0;
		u_host.mem[31] <= '0;
		ahb(1'h1, nwc_pkg::OFS_CTRL, 32'h1);
		idle();
		check("sweep out", 32'h89abcdef, {u_host.mem[31], u_host.mem[30]});
		ahb(1'h1, nwc_pkg::OFS_SEL, 32'h2);
		ahb(1'h0, nwc_pkg::OFS_VALUE, '0);
		check("sweep in", 32'h2a, r);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'h0, nwc_pkg::OFS_VALUE, '0);
		check("reset", nwc_pkg::RESET_VALUE, r);
		final_report();
	end
	initial begin
		repeat (20000) @(posedge hclk);
		failures++;
		final_report();
	end
endmodule : test_numeral_table_host_word_codec
`default_nettype wire
